// File: hdl/idc_dac_ctrl.sv
// I2C DAC command and control logic: slave shift logic on SCL, registers on clock.
// Assumes open-drain SDA resolved outside, SCL idle high between frames.
//
// What this block does
// - Write: address, command byte, two data bytes
// - Answer address 10011, select pin, zero
// - Output-code load also refreshes input register
// - Update command copies input to output code
// - Combined write loads output code and input
// - Control bits: reset, powerdown pair, ref, gain
// - Gain bit selects one or two times span
// - Reference disable bit, default reference on
// - Powerdown pair selects output termination mode
// - Powerdown leaves reference on unless disabled
// - Output code kept and writable while powered down
// - Software reset restores defaults, self clears
// - Read returns input register as two bytes
// - Strobe low during write loads output immediately
// - Strobe falling edge after stop loads output
// - Strobe pulses during bus access ignored
// - Hardware reset restores all registers, zero output
// - Commands ignored in reset, zero after release
// - Reference starts only after reset release
`timescale 1ns/10ps
module idc_dac_ctrl
    import idc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_pin,
    input wire logic load_strobe_n,
    output logic [CODE_W-1:0] analog_out_code,
    output logic gain_x2,
    output logic ref_on,
    output logic powerdown_sel_hi,
    output logic powerdown_sel_lo,
    output logic out_buf_en
);
    // ----------------------------------------
    // Link clear from start and stop detection
    // ----------------------------------------
    logic [3:0] sync1_reg, sync2_reg, sync3_reg;
    logic start_det, stop_det, frame_active_reg, clr_reg;
    logic [3:0] clr_cnt_reg;
    logic link_rst_n;
    // Link toggle that announces each complete write to the register file
    logic wr_tog_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Idle levels of the pins and the cleared toggle, so no false edge after reset
            sync1_reg <= 4'he;
            sync2_reg <= 4'he;
            sync3_reg <= 4'he;
        end else begin
            sync1_reg <= {scl, sda_i, load_strobe_n, wr_tog_reg};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign start_det = sync2_reg[3] & sync3_reg[3] & sync3_reg[2] & ~sync2_reg[2];
    assign stop_det = sync2_reg[3] & sync3_reg[3] & ~sync3_reg[2] & sync2_reg[2];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frame_active_reg <= 1'b0;
            clr_cnt_reg <= 4'h0;
            clr_reg <= 1'b0;
        end else begin
            if (start_det)
                frame_active_reg <= 1'b1;
            else if (stop_det)
                frame_active_reg <= 1'b0;
            if (start_det | stop_det)
                clr_cnt_reg <= 4'(LINK_CLR_CYC);
            else if (clr_cnt_reg != 4'h0)
                clr_cnt_reg <= clr_cnt_reg - 4'h1;
            clr_reg <= start_det | stop_det | (clr_cnt_reg > 4'h1);
        end
    end

    // Released while SCL is still high after start, well before its next edge
    assign link_rst_n = rstn & ~clr_reg;

    // ----------------------------------------
    // Link side: bit sampling on SCL rise
    // ----------------------------------------
    logic as_s1_reg, as_s2_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shreg_reg;
    logic [2:0] idx_reg;
    logic mack_reg, acc_reg, rw_reg, addr_hit, drive_rd;
    logic sda_o_reg, sda_oe_reg;
    logic [CODE_W-1:0] rd_shift_reg, in_reg, dac_reg;
    logic [7:0] cmd_reg, dhi_reg, dlo_reg;

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            as_s1_reg <= 1'b0;
            as_s2_reg <= 1'b0;
        end else begin
            as_s1_reg <= addr_select_pin;
            as_s2_reg <= as_s1_reg;
        end
    end

    always_ff @(posedge scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= 4'h0;
            shreg_reg <= 8'h00;
            idx_reg <= 3'h0;
            mack_reg <= 1'b0;
        end else if (bit_cnt_reg == BIT_ACK) begin
            bit_cnt_reg <= 4'h0;
            mack_reg <= ~sda_i;
            if (idx_reg != IDX_OVER)
                idx_reg <= idx_reg + 3'h1;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shreg_reg <= {shreg_reg[6:0], sda_i};
        end
    end

    // ----------------------------------------
    // Link side: SDA drive on SCL fall
    // ----------------------------------------
    assign addr_hit = shreg_reg[7:1] == {ADDR_HI, as_s2_reg, 1'b0};
    assign drive_rd = acc_reg & rw_reg & ((bit_cnt_reg != 4'h0) | mack_reg);

    always_ff @(negedge scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            acc_reg <= 1'b0;
            rw_reg <= 1'b0;
            sda_o_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            rd_shift_reg <= CODE_RESET;
        end else if (bit_cnt_reg == BIT_ACK) begin
            sda_o_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            if (idx_reg == 3'h0 && addr_hit) begin
                acc_reg <= 1'b1;
                rw_reg <= shreg_reg[0];
                sda_oe_reg <= 1'b1;
                // Input register only changes on bus writes, so it is quiet here
                rd_shift_reg <= in_reg;
            end else if (acc_reg && !rw_reg && idx_reg != IDX_OVER) begin
                sda_oe_reg <= 1'b1;
            end
        end else if (drive_rd) begin
            sda_o_reg <= rd_shift_reg[CODE_W-1];
            sda_oe_reg <= ~rd_shift_reg[CODE_W-1];
            rd_shift_reg <= {rd_shift_reg[CODE_W-2:0], 1'b0};
        end else begin
            sda_oe_reg <= 1'b0;
            if (bit_cnt_reg == 4'h0 && !mack_reg)
                acc_reg <= 1'b0;
        end
    end

    // Not cleared by framing, so the toggle never makes a false event
    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            cmd_reg <= 8'h00;
            dhi_reg <= 8'h00;
            dlo_reg <= 8'h00;
            wr_tog_reg <= 1'b0;
        end else if (bit_cnt_reg == BIT_ACK && acc_reg && !rw_reg) begin
            case (idx_reg)
                IDX_CMD: cmd_reg <= shreg_reg;
                IDX_HI: dhi_reg <= shreg_reg;
                IDX_LO: begin
                    dlo_reg <= shreg_reg;
                    wr_tog_reg <= ~wr_tog_reg;
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register file on the system clock
    // ----------------------------------------
    logic wr_evt, ld_fall;
    logic [3:0] cmd;
    logic [CODE_W-1:0] word;
    logic [CTRL_W-1:0] ctrl_reg;
    logic ref_on_reg, buf_en_reg;

    assign wr_evt = sync2_reg[0] ^ sync3_reg[0];
    assign ld_fall = sync3_reg[1] & ~sync2_reg[1];
    assign cmd = cmd_reg[7:4];
    assign word = {dhi_reg, dlo_reg};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            in_reg <= CODE_RESET;
            dac_reg <= CODE_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (wr_evt) begin
            case (cmd)
                CMD_WR_IN: begin
                    in_reg <= word;
                    if (!sync2_reg[1])
                        dac_reg <= word;
                end
                CMD_UPDATE: dac_reg <= in_reg;
                CMD_WR_DAC: begin
                    dac_reg <= word;
                    in_reg <= word;
                end
                CMD_WR_CTRL: begin
                    if (word[CTL_RST]) begin
                        in_reg <= CODE_RESET;
                        dac_reg <= CODE_RESET;
                        ctrl_reg <= CTRL_RESET;
                    end else begin
                        ctrl_reg <= word[CTL_PD_HI:CTL_GAIN];
                    end
                end
                default: ;
            endcase
        end else if (ld_fall && !frame_active_reg) begin
            dac_reg <= in_reg;
        end
    end

    // Reference only starts once out of reset, and powerdown never stops it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_on_reg <= 1'b0;
            buf_en_reg <= 1'b0;
        end else begin
            ref_on_reg <= ~ctrl_reg[CTL_REF-CTL_GAIN];
            buf_en_reg <= ctrl_reg[CTL_PD_HI-CTL_GAIN:CTL_PD_LO-CTL_GAIN] == 2'b00;
        end
    end

    assign sda_o = sda_o_reg;
    assign sda_oe = sda_oe_reg;
    assign analog_out_code = dac_reg;
    assign gain_x2 = ctrl_reg[0];
    assign ref_on = ref_on_reg;
    assign powerdown_sel_hi = ctrl_reg[CTL_PD_HI-CTL_GAIN];
    assign powerdown_sel_lo = ctrl_reg[CTL_PD_LO-CTL_GAIN];
    assign out_buf_en = buf_en_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_addr_ack: assert property (@(negedge scl) disable iff (!link_rst_n)
        (bit_cnt_reg == BIT_ACK && idx_reg == 3'h0 && addr_hit) |=> (sda_oe_reg && !sda_o_reg))
        else $error("address match not acknowledged");
    a_update_copy: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_UPDATE) |=> dac_reg == $past(in_reg))
        else $error("update did not copy input register");
    a_write_both: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_WR_DAC) |=> (dac_reg == $past(word) && in_reg == dac_reg))
        else $error("combined write mismatch");
    a_sync_load: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_WR_IN && !sync2_reg[1]) |=> dac_reg == $past(word))
        else $error("strobe low write did not load output");
    a_async_load: assert property (@(posedge clock) disable iff (!rstn)
        (ld_fall && !frame_active_reg && !wr_evt) |=> dac_reg == $past(in_reg))
        else $error("strobe edge did not load output");
    a_strobe_busy: assert property (@(posedge clock) disable iff (!rstn)
        (ld_fall && frame_active_reg && !wr_evt) |=> $stable(dac_reg))
        else $error("strobe acted during bus access");
    a_soft_reset: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_WR_CTRL && word[CTL_RST])
        |=> (dac_reg == CODE_RESET && in_reg == CODE_RESET && ctrl_reg == CTRL_RESET))
        else $error("software reset incomplete");
    a_nop_cmd: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && (cmd > CMD_WR_CTRL || cmd == CMD_NOP))
        |=> ($stable(dac_reg) && $stable(in_reg) && $stable(ctrl_reg)))
        else $error("undefined command changed state");
    a_pd_ref: assert property (@(posedge clock) disable iff (!rstn)
        (ctrl_reg[3:2] != 2'b00 && !ctrl_reg[1]) [*2] |-> (ref_on_reg && !out_buf_en))
        else $error("powerdown state wrong");
    a_data_ack: assert property (@(negedge scl) disable iff (!link_rst_n)
        (bit_cnt_reg == BIT_ACK && acc_reg && !rw_reg && idx_reg != IDX_OVER)
        |=> (sda_oe_reg && !sda_o_reg))
        else $error("write byte not acknowledged");
    a_read_release: assert property (@(negedge scl) disable iff (!link_rst_n)
        (bit_cnt_reg == 4'h0 && !mack_reg && rw_reg) |=> !sda_oe_reg)
        else $error("SDA held after master nack");
    a_ctrl_fields: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_WR_CTRL && !word[CTL_RST])
        |=> ctrl_reg == word[CTL_PD_HI:CTL_GAIN])
        else $error("control word fields misplaced");
    a_input_write: assert property (@(posedge clock) disable iff (!rstn)
        (wr_evt && cmd == CMD_WR_IN) |=> in_reg == word)
        else $error("input register write lost");
endmodule : idc_dac_ctrl

// File: hdl/idc_pkg.sv
// Constants shared by the I2C DAC command and control block.
// Assumes a 100 MHz system clock and an I2C link clocked by SCL.
package idc_pkg;
    // ----------------------------------------
    // Bus address and commands
    // ----------------------------------------
    localparam logic [4:0] ADDR_HI = 5'h13;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_IN = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WR_DAC = 4'h3;
    localparam logic [3:0] CMD_WR_CTRL = 4'h4;
    // ----------------------------------------
    // Control word layout
    // ----------------------------------------
    localparam int CTL_RST = 15;
    localparam int CTL_PD_HI = 14;
    localparam int CTL_PD_LO = 13;
    localparam int CTL_REF = 12;
    localparam int CTL_GAIN = 11;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    localparam int CODE_W = 16;
    localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
    // ----------------------------------------
    // Link framing and timing
    // ----------------------------------------
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [2:0] IDX_CMD = 3'h1;
    localparam logic [2:0] IDX_HI = 3'h2;
    localparam logic [2:0] IDX_LO = 3'h3;
    localparam logic [2:0] IDX_OVER = 3'h4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_CLR_NS = 40;
    localparam int LINK_CLR_CYC = (LINK_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : idc_pkg

// File: tb/i2c_dac_command_control_tb.sv
// Self-checking bench for the I2C DAC command and control block.
// Assumes the master model in tb/ and an SDA pull-up resolved here.
`timescale 1ns/10ps
module i2c_dac_command_control_tb;
    import idc_pkg::*;
    typedef struct packed {
        logic [3:0] cmd;
        logic [15:0] word;
        logic ld_n;
        logic [15:0] code;
        logic [15:0] rb;
        logic [4:0] outs;
    } idc_row_t;
    localparam logic [6:0] ADDR0 = {ADDR_HI, 2'b00};
    localparam logic [6:0] ADDR1 = {ADDR_HI, 2'b10};
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic addr_select_pin = 1'b0;
    logic load_strobe_n = 1'b1;
    logic scl, sda_pull, sda_o, sda_oe, gain_x2, ref_on, pd_hi, pd_lo, out_buf_en;
    logic [15:0] analog_out_code, rb;
    logic [3:0] acks;
    logic ack;
    int fail_count = 0;
    int cmp_count = 0;
    wire sda_line = ~((sda_oe & ~sda_o) | sda_pull);
    wire [4:0] outs = {gain_x2, ref_on, pd_hi, pd_lo, out_buf_en};
    // ----------------------------------------
    // Rows: command, word, strobe; then code, readback, outputs
    // ----------------------------------------
    idc_row_t rows [14] = '{
        '{4'h1, 16'h1234, 1'b1, 16'h0000, 16'h1234, 5'h09},
        '{4'h2, 16'hffff, 1'b1, 16'h1234, 16'h1234, 5'h09},
        '{4'h1, 16'habcd, 1'b0, 16'habcd, 16'habcd, 5'h09},
        '{4'h3, 16'h5a5a, 1'b1, 16'h5a5a, 16'h5a5a, 5'h09},
        '{4'hf, 16'h1111, 1'b1, 16'h5a5a, 16'h5a5a, 5'h09},
        '{4'h0, 16'h2222, 1'b1, 16'h5a5a, 16'h5a5a, 5'h09},
        '{4'h4, 16'h0800, 1'b1, 16'h5a5a, 16'h5a5a, 5'h19},
        '{4'h4, 16'h1000, 1'b1, 16'h5a5a, 16'h5a5a, 5'h01},
        '{4'h4, 16'h2000, 1'b1, 16'h5a5a, 16'h5a5a, 5'h0a},
        '{4'h4, 16'h4000, 1'b1, 16'h5a5a, 16'h5a5a, 5'h0c},
        '{4'h4, 16'h7000, 1'b1, 16'h5a5a, 16'h5a5a, 5'h06},
        '{4'h4, 16'h6000, 1'b1, 16'h5a5a, 16'h5a5a, 5'h0e},
        '{4'h3, 16'h0f0f, 1'b1, 16'h0f0f, 16'h0f0f, 5'h0e},
        '{4'h4, 16'h8000, 1'b1, 16'h0000, 16'h0000, 5'h09}
    };
    always #5 clock = ~clock;
    idc_dac_ctrl dut (.clock(clock), .rstn(rstn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .load_strobe_n(load_strobe_n),
        .analog_out_code(analog_out_code), .gain_x2(gain_x2), .ref_on(ref_on),
        .powerdown_sel_hi(pd_hi), .powerdown_sel_lo(pd_lo), .out_buf_en(out_buf_en));
    idc_i2c_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t ns: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run needs about 47 us; the margin covers a stuck handshake
    initial begin
        #150000;
        fail_count++;
        $display("MISMATCH at %0t ns: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        // Low for at least 75 ns before release
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check({11'h0, outs}, 16'h0009, "defaults after reset");
        foreach (rows[i]) begin
            @(posedge clock);
            load_strobe_n <= rows[i].ld_n;
            repeat (4) @(posedge clock);
            m.wr(ADDR0, {rows[i].cmd, 4'h0}, rows[i].word, acks);
            check({12'h0, acks}, 16'h000f, "write acks");
            repeat (8) @(posedge clock);
            check(analog_out_code, rows[i].code, "code");
            check({11'h0, outs}, {11'h0, rows[i].outs}, "ctrl");
            m.rd(ADDR0, rb, ack);
            check({15'h0, ack}, 16'h0001, "read ack");
            check(rb, rows[i].rb, "readback");
        end
        // Last row leaves powerdown; give the output time to settle
        repeat (400) @(posedge clock);
        m.wr(ADDR1, 8'h10, 16'h4321, acks);
        check({12'h0, acks}, 16'h0000, "foreign address");
        @(posedge clock);
        addr_select_pin <= 1'b1;
        repeat (4) @(posedge clock);
        m.wr(ADDR1, 8'h10, 16'h4321, acks);
        check({12'h0, acks}, 16'h000f, "selected address");
        @(posedge clock);
        addr_select_pin <= 1'b0;
        // Strobe pulse inside a frame must not move the input to the output
        fork
            m.wr(ADDR0, 8'h10, 16'h7777, acks);
            begin
                #400;
                @(posedge clock);
                load_strobe_n <= 1'b0;
                repeat (10) @(posedge clock);
                load_strobe_n <= 1'b1;
            end
        join
        repeat (8) @(posedge clock);
        check(analog_out_code, 16'h0000, "strobe in frame");
        load_strobe_n <= 1'b0;
        repeat (8) @(posedge clock);
        check(analog_out_code, 16'h7777, "strobe after stop");
        load_strobe_n <= 1'b1;
        rstn <= 1'b0;
        m.wr(ADDR0, 8'h30, 16'h1111, acks);
        check({11'h0, outs}, 16'h0000, "outputs in reset");
        check(analog_out_code, 16'h0000, "code in reset");
        @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check({11'h0, outs}, 16'h0009, "outputs after reset");
        check(analog_out_code, 16'h0000, "code after reset");
        m.rd(ADDR0, rb, ack);
        check(rb, 16'h0000, "input after reset");
        tally_and_finish();
    end
endmodule : i2c_dac_command_control_tb

// File: tb/idc_i2c_master.sv
// I2C bus master model: drives SCL, pulls SDA low as an open-drain party.
// Assumes the bench resolves SDA with a pull-up and feeds the level back.
`timescale 1ns/10ps
module idc_i2c_master (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // SCL stands high outside frames and runs at a 30 ns period inside them
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #5;
            sda_pull = ~tx[i];
            #10;
            scl = 1'b1;
            rx[i] = sda;
            #15;
            scl = 1'b0;
        end
        #5;
        sda_pull = mack;
        #10;
        scl = 1'b1;
        ack = ~sda;
        #15;
        scl = 1'b0;
    endtask : xfer
    // Long start and stop holds, so the sampled detector cannot miss them
    task automatic start();
        // Offset keeps every link edge clear of the system clock edges
        #3;
        sda_pull = 1'b1;
        #100;
        scl = 1'b0;
    endtask : start
    task automatic stop();
        #5;
        sda_pull = 1'b1;
        #10;
        scl = 1'b1;
        #60;
        sda_pull = 1'b0;
        #100;
    endtask : stop
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
                      output logic [3:0] acks);
        logic [7:0] junk;
        start();
        xfer({a, 1'b0}, 1'b0, junk, acks[3]);
        xfer(c, 1'b0, junk, acks[2]);
        xfer(w[15:8], 1'b0, junk, acks[1]);
        xfer(w[7:0], 1'b0, junk, acks[0]);
        stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] w, output logic ack);
        logic [7:0] junk;
        logic a2;
        start();
        xfer({a, 1'b1}, 1'b0, junk, ack);
        xfer(8'hff, 1'b1, w[15:8], a2);
        xfer(8'hff, 1'b0, w[7:0], a2);
        stop();
    endtask : rd
endmodule : idc_i2c_master
